// ===== core/codec_pkg.sv
// Shared constants for the codec sample timing control block
//==========================================================
// Notes on behaviour
// - Input gain of 1, 2 or 4 applies to primary and auxiliary inputs.
// - Control bit chooses primary or auxiliary input pair for receive path.
// - Control bit inserts or bypasses the receive bandpass filter.
// - Receive counter A divides master clock into the receive filter clock.
// - Receive counter B divides receive filter clock into the A/D strobe.
// - Transmit counter B divides transmit filter clock into the D/A strobe.
// - Asynchronous mode derives both filter clocks through separate counter chains.
// - Asynchronous mode sets D/A and A/D rates from their own dividers.
// - Synchronous mode clocks both filters from the transmit filter clock.
// - Synchronous mode takes the A/D strobe from the D/A timing.
// - Four serial modes: async or sync timing, byte or word framing.
// - Active-low reset initialises every register including control, except the FIFO word storage.
// - After reset, serial exchanges run without any configuration writes.
// - Reset loads both rate adjust registers with one.
// - Reset sets control bits 7, 6, 5, 2 and clears bits 4, 3.
// - Serial shift clock is the master clock divided by four.
// - Byte modes send each word as two bytes with separate frame syncs.
package codec_pkg;
   // Register word indices on the bus
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TXA = 4'h1;
   localparam logic [3:0] REG_TXB = 4'h2;
   localparam logic [3:0] REG_RXA = 4'h3;
   localparam logic [3:0] REG_RXB = 4'h4;
   localparam logic [3:0] REG_TXADJ = 4'h5;
   localparam logic [3:0] REG_RXADJ = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   // Control fields
   localparam int CTL_FILT = 2;
   localparam int CTL_LOOP = 3;
   localparam int CTL_AUX = 4;
   localparam int CTL_SYNC = 5;
   localparam int CTL_GAIN = 6;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'hE4;
   localparam logic [7:0] TXA_RESET = 8'h12;
   localparam logic [7:0] TXB_RESET = 8'h24;
   localparam logic [7:0] RXA_RESET = 8'h12;
   localparam logic [7:0] RXB_RESET = 8'h24;
   localparam logic [7:0] ADJ_RESET = 8'h01;
   // Serial framing
   localparam int WORD_BITS = 16;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [3:0] WORD_LAST = 4'hF;
   localparam logic [1:0] SHIFT_LAST = 2'h3;
   localparam int FIFO_DEPTH = 4;
endpackage

// ===== core/codec_timing_control.sv
// Sample timing, control register and serial port of the codec
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module codec_timing_control (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Serial pins
   input wire logic wordModePin,
   input wire logic serialDataToDevice,
   output logic serialDataFromDevice,
   output logic shiftClk,
   output logic frameSyncTx_n,
   output logic frameSyncRx_n,
   // Converter side
   input wire logic [15:0] adcSample,
   output logic [15:0] dacWord,
   output logic dacValid,
   input wire logic dacReady,
   output logic txFiltTick,
   output logic rxFiltTick,
   output logic dacStrobe,
   output logic adcStrobe,
   // Analog settings
   output logic [2:0] gainFactor,
   output logic auxSelect,
   output logic filterInsert,
   output logic loopbackEn
);
   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_GAP} frame_t;

   logic [7:0] ctrl;
   logic [7:0] txA;
   logic [7:0] txB;
   logic [7:0] rxA;
   logic [7:0] rxB;
   logic [7:0] txAdj;
   logic [7:0] rxAdj;
   logic ack;
   logic wrEn;
   logic syncMode;
   logic [7:0] txACnt;
   logic [7:0] txBCnt;
   logic [7:0] rxACnt;
   logic [7:0] rxBCnt;
   logic rxATick;
   logic rxBTick;
   logic [1:0] shiftDiv;
   logic bitTick;
   logic [1:0] wordSync;
   logic [1:0] dxSync;
   frame_t state;
   logic [3:0] bitCnt;
   logic pending;
   logic [15:0] adcHold;
   logic [15:0] txShift;
   logic [15:0] rxShift;
   logic pushValid;
   logic pushReady;
   logic frameStart;
   logic frameDone;
   logic [2:0] fifoLevel;
   logic seenClk;

   //==========================================================
   // Helpers
   function automatic logic expired(input logic [7:0] cnt);
      return cnt <= 8'h01;
   endfunction

   function automatic logic [7:0] countNext(input logic [7:0] cnt, input logic [7:0] load);
      return expired(cnt) ? load : cnt - 8'h01;
   endfunction

   function automatic logic [2:0] gainOf(input logic [1:0] code);
      case (code)
         2'h1: return 3'h2;
         2'h2: return 3'h4;
         default: return 3'h1;
      endcase
   endfunction

   //==========================================================
   // Register bus
   assign waitrequest = (read || write) && !ack;
   assign wrEn = write && ack;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (read || write) && !ack;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= codec_pkg::CTRL_RESET;
         txA <= codec_pkg::TXA_RESET;
         txB <= codec_pkg::TXB_RESET;
         rxA <= codec_pkg::RXA_RESET;
         rxB <= codec_pkg::RXB_RESET;
         txAdj <= codec_pkg::ADJ_RESET;
         rxAdj <= codec_pkg::ADJ_RESET;
      end else if (wrEn) begin
         case (address)
            codec_pkg::REG_CTRL: ctrl <= writedata[7:0];
            codec_pkg::REG_TXA: txA <= writedata[7:0];
            codec_pkg::REG_TXB: txB <= writedata[7:0];
            codec_pkg::REG_RXA: rxA <= writedata[7:0];
            codec_pkg::REG_RXB: rxB <= writedata[7:0];
            codec_pkg::REG_TXADJ: txAdj <= writedata[7:0];
            codec_pkg::REG_RXADJ: rxAdj <= writedata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= '0;
      end else if (read && !ack) begin
         case (address)
            codec_pkg::REG_CTRL: readdata <= {24'h00_0000, ctrl};
            codec_pkg::REG_TXA: readdata <= {24'h00_0000, txA};
            codec_pkg::REG_TXB: readdata <= {24'h00_0000, txB};
            codec_pkg::REG_RXA: readdata <= {24'h00_0000, rxA};
            codec_pkg::REG_RXB: readdata <= {24'h00_0000, rxB};
            codec_pkg::REG_TXADJ: readdata <= {24'h00_0000, txAdj};
            codec_pkg::REG_RXADJ: readdata <= {24'h00_0000, rxAdj};
            codec_pkg::REG_STATUS:
               readdata <= {24'h00_0000, pending, wordSync[1], state != ST_IDLE, 2'h0, fifoLevel};
            default: readdata <= '0;
         endcase
      end
   end

   //==========================================================
   // Analog settings
   assign syncMode = ctrl[codec_pkg::CTL_SYNC];
   assign gainFactor = gainOf(ctrl[codec_pkg::CTL_GAIN +: 2]);
   assign auxSelect = ctrl[codec_pkg::CTL_AUX];
   assign filterInsert = ctrl[codec_pkg::CTL_FILT];
   assign loopbackEn = ctrl[codec_pkg::CTL_LOOP];

   //==========================================================
   // Divider chains
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txACnt <= codec_pkg::TXA_RESET;
         txBCnt <= codec_pkg::TXB_RESET;
         txFiltTick <= 1'b0;
         dacStrobe <= 1'b0;
      end else begin
         txACnt <= countNext(txACnt, txA);
         txFiltTick <= expired(txACnt);
         dacStrobe <= txFiltTick && expired(txBCnt);
         if (txFiltTick) begin
            txBCnt <= countNext(txBCnt, txB);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxACnt <= codec_pkg::RXA_RESET;
         rxBCnt <= codec_pkg::RXB_RESET;
         rxATick <= 1'b0;
         rxBTick <= 1'b0;
      end else begin
         rxACnt <= countNext(rxACnt, rxA);
         rxATick <= expired(rxACnt);
         rxBTick <= rxFiltTick && expired(rxBCnt);
         if (rxFiltTick) begin
            rxBCnt <= countNext(rxBCnt, rxB);
         end
      end
   end

   assign rxFiltTick = syncMode ? txFiltTick : rxATick;
   assign adcStrobe = syncMode ? dacStrobe : rxBTick;

   //==========================================================
   // Pin synchronisers and shift clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wordSync <= 2'h0;
         dxSync <= 2'h0;
      end else begin
         wordSync <= {wordSync[0], wordModePin};
         dxSync <= {dxSync[0], serialDataToDevice};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shiftDiv <= 2'h0;
         shiftClk <= 1'b0;
      end else begin
         shiftDiv <= shiftDiv + 2'h1;
         shiftClk <= shiftDiv[1];
      end
   end

   assign bitTick = (shiftDiv == codec_pkg::SHIFT_LAST);

   //==========================================================
   // Serial frame engine
   assign frameStart = bitTick && state == ST_IDLE && pending && pushReady;
   assign frameDone = bitTick && state == ST_DATA && bitCnt == codec_pkg::WORD_LAST;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (dacStrobe) begin
         pending <= 1'b1;
      end else if (frameStart) begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         adcHold <= '0;
      end else if (adcStrobe) begin
         adcHold <= adcSample;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bitCnt <= 4'h0;
         txShift <= '0;
         rxShift <= '0;
      end else if (bitTick) begin
         case (state)
            ST_IDLE: begin
               if (frameStart) begin
                  state <= ST_DATA;
                  bitCnt <= 4'h0;
                  txShift <= adcHold;
               end
            end
            ST_DATA: begin
               rxShift <= {rxShift[14:0], dxSync[1]};
               txShift <= {txShift[14:0], 1'b0};
               bitCnt <= bitCnt + 4'h1;
               if (bitCnt == codec_pkg::WORD_LAST) begin
                  state <= ST_IDLE;
               end else if (bitCnt == codec_pkg::BYTE_LAST && !wordSync[1]) begin
                  state <= ST_GAP;
               end
            end
            ST_GAP: state <= ST_DATA;
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pushValid <= 1'b0;
      end else begin
         pushValid <= frameDone;
      end
   end

   assign serialDataFromDevice = txShift[15];
   assign frameSyncTx_n = (state != ST_DATA);
   assign frameSyncRx_n = (state != ST_DATA);

   //==========================================================
   // Received word buffer
   sample_fifo #(
      .WIDTH(codec_pkg::WORD_BITS),
      .DEPTH(codec_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(rxShift),
      .outValid(dacValid),
      .outReady(dacReady),
      .outData(dacWord),
      .level(fifoLevel)
   );

   //==========================================================
   // Checks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seenClk <= 1'b0;
      end else begin
         seenClk <= 1'b1;
      end
   end

   sequence shiftRise;
      !shiftClk ##1 shiftClk;
   endsequence

   sequence byteEnd;
      bitTick && state == ST_DATA && bitCnt == codec_pkg::BYTE_LAST;
   endsequence

   ctrl_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !seenClk |-> ctrl == codec_pkg::CTRL_RESET) else $error("control reset value wrong");
   adj_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !seenClk |-> txAdj == 8'h01 && rxAdj == 8'h01) else $error("rate adjust reset wrong");
   gain_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctrl[codec_pkg::CTL_GAIN +: 2] == 2'h1 |-> gainFactor == 3'h2)
      else $error("gain code mismatch");
   aux_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wrEn && address == codec_pkg::REG_CTRL |=>
      auxSelect == $past(writedata[codec_pkg::CTL_AUX]))
      else $error("aux select not updated");
   filt_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wrEn && address == codec_pkg::REG_CTRL |=>
      filterInsert == $past(writedata[codec_pkg::CTL_FILT]))
      else $error("filter select not updated");
   adc_div_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxBTick |-> $past(rxFiltTick)) else $error("adc strobe off filter tick");
   dac_div_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dacStrobe |-> $past(txFiltTick)) else $error("dac strobe off filter tick");
   sync_filt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      syncMode |-> rxFiltTick == txFiltTick) else $error("filter clocks differ in sync");
   sync_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      syncMode |-> adcStrobe == dacStrobe) else $error("strobes differ in sync");
   shift_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shiftRise |-> ##3 shiftRise) else $error("shift clock period not four");
   byte_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      byteEnd ##0 !wordSync[1] |=> frameSyncTx_n && frameSyncRx_n)
      else $error("no sync gap between bytes");
   tick_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      txFiltTick && txACnt > 8'h01 |=> !txFiltTick)
      else $error("filter tick wider than one cycle");
   push_room_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pushValid |-> pushReady) else $error("received word dropped");
endmodule // codec_timing_control

// ===== core/sample_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic push;
   logic pop;

   assign inReady = (level != (AW+1)'(DEPTH));
   assign outValid = (level != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         level <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sample_fifo

// ===== verif/codec_timing_control_tb.sv
// Self-checking bench for the codec sample timing control block
`timescale 1ns/1ps
module codec_timing_control_tb;
   //==========================================================
   // Signals
   logic clk_sys, rst_n = 1'b0, read = 1'b0, write = 1'b0, wordModePin = 1'b1, dacReady = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0000_0000, readdata, q;
   logic [15:0] adcSample = 16'hC35A, hostWord = 16'h5A3C, dacWord, rxLast;
   logic waitrequest, serialDataToDevice, serialDataFromDevice, shiftClk, frameSyncTx_n;
   logic frameSyncRx_n, dacValid, txFiltTick, rxFiltTick, dacStrobe, adcStrobe;
   logic auxSelect, filterInsert, loopbackEn;
   logic [2:0] gainFactor;
   logic [6:0] lowRun;
   logic [7:0] frameCount;
   int badCount = 0, testsRun = 0;

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   codec_timing_control u_dut (.clk_sys, .rst_n, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .wordModePin, .serialDataToDevice, .serialDataFromDevice,
      .shiftClk, .frameSyncTx_n, .frameSyncRx_n, .adcSample, .dacWord, .dacValid, .dacReady,
      .txFiltTick, .rxFiltTick, .dacStrobe, .adcStrobe, .gainFactor, .auxSelect,
      .filterInsert, .loopbackEn);

   dsp_serial_model u_host (.clk_sys, .rst_n, .frameSyncTx_n, .frameSyncRx_n,
      .serialDataFromDevice, .serialDataToDevice, .hostWord, .rxLast, .lowRun, .frameCount);

   //==========================================================
   // Shared tasks
   task automatic finishTest;
      if (badCount == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic timedOut;
      badCount++;
      finishTest();
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      address <= a;
      writedata <= {24'h00_0000, d};
      read <= ~wr;
      write <= wr;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) timedOut();
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(q, {24'h00_0000, exp});
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return txFiltTick;
         1: return rxFiltTick;
         2: return dacStrobe;
         default: return adcStrobe;
      endcase
   endfunction

   task automatic period(input int s, input int exp);
      int n;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pick(s) !== 1'b1 && n < 2000);
      if (n >= 2000) timedOut();
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pick(s) !== 1'b1 && n < 2000);
      if (n >= 2000) timedOut();
      check(n, exp);
   endtask

   task automatic frame;
      logic [7:0] f;
      int n;
      f = frameCount;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (frameCount === f && n < 3000);
      if (n >= 3000) timedOut();
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic drain(input int exp);
      int n;
      n = 0;
      dacReady <= 1'b1;
      repeat (8) begin
         @(posedge clk_sys);
         if (dacValid === 1'b1 && dacReady === 1'b1) begin
            n++;
            check(dacWord, hostWord);
         end
      end
      dacReady <= 1'b0;
      check(n, exp);
      check(dacValid, 1'b0);
   endtask

   task automatic resetDut(input logic wm);
      rst_n <= 1'b0;
      wordModePin <= wm;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask

   //==========================================================
   // Scenarios
   task automatic scenResetValues;
      check({gainFactor, auxSelect, filterInsert, loopbackEn}, {3'h1, 3'h2});
      rd(codec_pkg::REG_CTRL, codec_pkg::CTRL_RESET);
      rd(codec_pkg::REG_TXA, codec_pkg::TXA_RESET);
      rd(codec_pkg::REG_TXB, codec_pkg::TXB_RESET);
      rd(codec_pkg::REG_RXA, codec_pkg::RXA_RESET);
      rd(codec_pkg::REG_RXB, codec_pkg::RXB_RESET);
      rd(codec_pkg::REG_TXADJ, codec_pkg::ADJ_RESET);
      rd(codec_pkg::REG_RXADJ, codec_pkg::ADJ_RESET);
      bus(1'b1, 4'h9, 8'hFF);
      rd(4'h9, 8'h00);
      rd(codec_pkg::REG_CTRL, codec_pkg::CTRL_RESET);
   endtask

   task automatic scenFirstFrame;
      int n;
      logic s;
      frame();
      check(rxLast, adcSample);
      check(lowRun, 7'h40);
      n = 0;
      s = shiftClk;
      repeat (16) begin
         @(posedge clk_sys);
         if (shiftClk !== s) n++;
         s = shiftClk;
      end
      check(n, 8);
      drain(1);
   endtask

   task automatic scenControl;
      logic [1:0] g;
      for (int i = 0; i < 4; i++) begin
         g = i[1:0];
         bus(1'b1, codec_pkg::REG_CTRL, {g, 1'b1, g[0], g[1], ~g[0], 2'h0});
         check({gainFactor, auxSelect, loopbackEn, filterInsert}, {(g == 2'h1) ? 3'h2 :
            ((g == 2'h2) ? 3'h4 : 3'h1), g[0], g[1], ~g[0]});
      end
   endtask

   task automatic scenTiming;
      bus(1'b1, codec_pkg::REG_CTRL, 8'hE4);
      bus(1'b1, codec_pkg::REG_TXA, 8'h03);
      bus(1'b1, codec_pkg::REG_TXB, 8'h02);
      period(0, 3);
      period(2, 6);
      repeat (12) begin
         @(posedge clk_sys);
         check({rxFiltTick, adcStrobe}, {txFiltTick, dacStrobe});
      end
      bus(1'b1, codec_pkg::REG_CTRL, 8'hC4);
      bus(1'b1, codec_pkg::REG_RXA, 8'h05);
      bus(1'b1, codec_pkg::REG_RXB, 8'h03);
      period(1, 5);
      period(3, 15);
      period(2, 6);
   endtask

   task automatic scenByte;
      resetDut(1'b0);
      hostWord <= 16'h96E1;
      adcSample <= 16'h3C81;
      frame();
      check(rxLast, adcSample);
      check(lowRun, 7'h20);
      drain(1);
   endtask

   task automatic scenFifo;
      bus(1'b1, codec_pkg::REG_TXB, 8'h0A);
      repeat (1500) @(posedge clk_sys);
      bus(1'b0, codec_pkg::REG_STATUS, 8'h00);
      check(q[2:0], 3'h4);
      drain(4);
   endtask

   //==========================================================
   // Main sequence
   initial begin
      resetDut(1'b1);
      scenResetValues();
      scenFirstFrame();
      scenControl();
      scenTiming();
      scenByte();
      scenFifo();
      finishTest();
   end
endmodule // codec_timing_control_tb

// ===== verif/dsp_serial_model.sv
// Host serial port model facing the codec serial pins
`timescale 1ns/1ps
module dsp_serial_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial pins
   input wire logic frameSyncTx_n,
   input wire logic frameSyncRx_n,
   input wire logic serialDataFromDevice,
   output logic serialDataToDevice,
   // Host side
   input wire logic [15:0] hostWord,
   output logic [15:0] rxLast,
   output logic [6:0] lowRun,
   output logic [7:0] frameCount
);
   //==========================================================
   // Bit counting across sync-low periods
   logic [5:0] cnt;
   logic [6:0] run;
   logic [15:0] rxShift;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 6'h00;
         run <= 7'h00;
         rxShift <= 16'h0000;
         rxLast <= 16'h0000;
         lowRun <= 7'h00;
         frameCount <= 8'h00;
         serialDataToDevice <= 1'b0;
      end else if (!frameSyncTx_n) begin
         // MSB first, bytes continue the same word count
         serialDataToDevice <= hostWord[4'hF - cnt[5:2]];
         cnt <= cnt + 6'h01;
         run <= run + 7'h01;
         if (cnt[1:0] == 2'h1 && !frameSyncRx_n) begin
            rxShift <= {rxShift[14:0], serialDataFromDevice};
         end
         if (cnt == 6'h3F) begin
            rxLast <= rxShift;
            frameCount <= frameCount + 8'h01;
         end
      end else begin
         // Released line keeps changing
         serialDataToDevice <= ~serialDataToDevice;
         if (run != 7'h00) begin
            lowRun <= run;
         end
         run <= 7'h00;
      end
   end
endmodule // dsp_serial_model
